// ==== include/lss_defines.vh ====
// Overview of operation
// R1: Latch-load and output-enable act by level, never sampled at shift edges.
// R2: Latch-load low holds the output latches unchanged.
// R3: Latch-load high makes latches follow the shift register continuously.
// R4: Output enable low drives each sink channel from its latch bit.
// R5: Enabled channel conducts for latch bit one, off for zero.
// R6: Output enable high switches every sink channel off.
// R7: Each rising shift-clock edge samples serial input and shifts one bit on.
// R8: Newest bit at channel 0, channel k is k clocks old; output shows channel 15.
// R9: Controller holds serial input stable around each rising shift-clock edge.
// R10: Over-temperature forces all sink channels off regardless of latches.
// R11: Channels resume once temperature falls back by the hysteresis.
// R12: Undriven latch-load reads low, undriven output enable reads high.
// R13: Controller always drives shift clock and serial input to defined levels.
// R14: Controller shifts sixteen bits per cascaded device before pulsing latch-load.
// R15: Falling shift-clock edges change neither shift register nor serial output.
`ifndef LSS_DEFINES_VH
`define LSS_DEFINES_VH
`define LSS_CHANNELS 16
`define LSS_MSB 15
`define LSS_FIFO_DEPTH 8
`define LSS_FIFO_AW 3
`define LSS_ADDR_W 5
`define LSS_REG_CTRL 5'h00
`define LSS_REG_STATUS 5'h04
`define LSS_REG_SHIFT 5'h08
`define LSS_REG_LATCH 5'h0c
`define LSS_REG_CAPTURE 5'h10
`define LSS_CTRL_FORCE_OFF 0
`define LSS_CTRL_CAPTURE_EN 1
`define LSS_ST_THERMAL 0
`define LSS_ST_NOT_EMPTY 1
`define LSS_ST_OVERFLOW 2
`define LSS_ST_FULL 3
`define LSS_CTRL_RESET 2'h0
`endif

// ==== core/lss_fifo.v ====
`timescale 1ns/10ps
`default_nettype none
module lss_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      // Depth is a power of two, pointers wrap naturally
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/lss_core.v ====
`timescale 1ns/10ps
`default_nettype none
`include "lss_defines.vh"
module lss_core (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Serial link pins
  input wire shift_clk,
  input wire serial_in,
  output reg serial_out,
  input wire latch_transparent,
  input wire out_enable_n,
  // Thermal comparator, already with hysteresis
  input wire over_temp,
  // Sink channels, bit 0 is the first, bit 15 the last
  output reg [`LSS_MSB:0] sink_channel,
  // Capture buffer back-pressure
  output wire capture_ready,
  // Avalon-MM slave
  input wire [`LSS_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);
  // Two-stage synchronisers
  reg sck_s1, sck_s2, sck_s3;
  reg sdi_s1, sdi_s2;
  reg le_s1, le_s2, le_s3;
  reg oen_s1, oen_s2;
  reg ot_s1, ot_s2;
  reg [`LSS_MSB:0] shift_reg;
  reg [`LSS_MSB:0] latch_reg;
  reg [1:0] ctrl;
  reg overflow;
  reg ack;
  wire shift_rise;
  wire le_rise;
  wire channels_enabled;
  wire fifo_valid;
  wire [`LSS_MSB:0] fifo_data;
  wire fifo_pop;
  wire capture_push;
  wire bus_req;
  wire bus_take;
  wire ovf_clear;
  reg [31:0] next_readdata;

  function sel;
    input [`LSS_ADDR_W-1:0] a;
    input [`LSS_ADDR_W-1:0] r;
    begin
      sel = (a == r);
    end
  endfunction

  // Pull defaults are pads; at reset the sync chain assumes them
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      le_s1 <= 1'b0; // R12
      le_s2 <= 1'b0;
      le_s3 <= 1'b0;
      oen_s1 <= 1'b1; // R12
      oen_s2 <= 1'b1;
      ot_s1 <= 1'b0;
      ot_s2 <= 1'b0;
    end else begin
      sck_s1 <= shift_clk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= serial_in;
      sdi_s2 <= sdi_s1;
      le_s1 <= latch_transparent;
      le_s2 <= le_s1;
      le_s3 <= le_s2;
      oen_s1 <= out_enable_n;
      oen_s2 <= oen_s1;
      ot_s1 <= over_temp;
      ot_s2 <= ot_s1;
    end
  end

  // Only the rising edge moves data; falling edges are ignored
  assign shift_rise = sck_s2 & ~sck_s3; // R7 R15
  assign le_rise = le_s2 & ~le_s3;

  // Data and clock chains have equal depth, so the bit seen with the edge
  // is the one present at the pin edge; needs shift clock below 10 MHz
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= {`LSS_CHANNELS{1'b0}};
      serial_out <= 1'b0;
    end else if (shift_rise) begin // R9
      shift_reg <= {shift_reg[`LSS_MSB-1:0], sdi_s2}; // R7 R8
      serial_out <= shift_reg[`LSS_MSB-1]; // R8
    end
  end

  // Level driven, independent of shift edges
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= {`LSS_CHANNELS{1'b0}};
    end else if (le_s2) begin // R1
      latch_reg <= shift_reg; // R3
    end
  end // R2: no assignment while low

  assign channels_enabled = ~oen_s2 & ~ot_s2 & ~ctrl[`LSS_CTRL_FORCE_OFF]; // R1 R6 R10 R11

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sink_channel <= {`LSS_CHANNELS{1'b0}};
    end else if (channels_enabled) begin
      sink_channel <= latch_reg; // R4 R5
    end else begin
      sink_channel <= {`LSS_CHANNELS{1'b0}}; // R6 R10
    end
  end

  // Captures each frame the controller loads, for software readback
  assign capture_push = le_rise & ctrl[`LSS_CTRL_CAPTURE_EN];

  lss_fifo #(
    .WIDTH(`LSS_CHANNELS),
    .DEPTH(`LSS_FIFO_DEPTH),
    .AW(`LSS_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(capture_push),
    .in_ready(capture_ready),
    .in_data(shift_reg),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Bus: every access answers exactly one cycle after it appears
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  assign bus_take = bus_req & ack;
  assign fifo_pop = bus_take & avs_read & sel(avs_address, `LSS_REG_CAPTURE);
  assign ovf_clear = bus_take & avs_write & sel(avs_address, `LSS_REG_STATUS)
    & avs_writedata[`LSS_ST_OVERFLOW];

  always @* begin
    next_readdata = 32'h0;
    if (sel(avs_address, `LSS_REG_CTRL)) begin
      next_readdata[1:0] = ctrl;
    end else if (sel(avs_address, `LSS_REG_STATUS)) begin
      next_readdata[`LSS_ST_THERMAL] = ot_s2;
      next_readdata[`LSS_ST_NOT_EMPTY] = fifo_valid;
      next_readdata[`LSS_ST_OVERFLOW] = overflow;
      next_readdata[`LSS_ST_FULL] = ~capture_ready;
    end else if (sel(avs_address, `LSS_REG_SHIFT)) begin
      next_readdata[`LSS_MSB:0] = shift_reg;
    end else if (sel(avs_address, `LSS_REG_LATCH)) begin
      next_readdata[`LSS_MSB:0] = latch_reg;
    end else if (sel(avs_address, `LSS_REG_CAPTURE)) begin
      // Empty buffer reads as zero
      next_readdata[`LSS_MSB:0] = fifo_valid ? fifo_data : {`LSS_CHANNELS{1'b0}};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl <= `LSS_CTRL_RESET;
      overflow <= 1'b0;
    end else begin
      ack <= avs_waitrequest;
      if (avs_waitrequest && avs_read) begin
        avs_readdata <= next_readdata;
      end
      if (bus_take && avs_write && sel(avs_address, `LSS_REG_CTRL)) begin
        ctrl <= avs_writedata[1:0];
      end
      // A dropped frame in the clearing cycle still sets the flag
      if (capture_push && !capture_ready) begin
        overflow <= 1'b1;
      end else if (ovf_clear) begin
        overflow <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/lss_chk_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module lss_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins
  input wire logic shift_clk,
  input wire logic serial_out,
  input wire logic latch_transparent,
  input wire logic out_enable_n,
  input wire logic over_temp,
  input wire logic [15:0] sink_channel,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  wire quiet = !out_enable_n && !over_temp;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  off_disabled_a: assert property (out_enable_n [*6] |-> sink_channel == 16'h0)
    else $error("lit while disabled");
  off_prompt_a: assert property ($rose(out_enable_n) |-> ##[1:6] sink_channel == 16'h0)
    else $error("disable ignored");
  off_thermal_a: assert property (over_temp [*6] |-> sink_channel == 16'h0)
    else $error("lit while hot");
  latch_hold_a: assert property ((quiet && !latch_transparent && !avs_write) [*6] |-> $stable(sink_channel))
    else $error("held latch moved");
  out_last_a: assert property ((quiet && latch_transparent && !shift_clk) [*6] ##0 sink_channel[15] |-> serial_out)
    else $error("serial out not last channel");
  shift_only_a: assert property ($changed(serial_out) |-> $past(shift_clk, 2) || $past(shift_clk, 3))
    else $error("serial out moved without rise");
  req_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
endmodule
bind lss_core lss_chk chk (.clk, .arst_n, .shift_clk, .serial_out, .latch_transparent, .out_enable_n,
  .over_temp, .sink_channel, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// ==== bench/lss_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lss_ctrl_model (
  // Clock
  input wire logic clk,
  // Controller pins
  output logic shift_clk = 1'h0,
  output logic serial_in = 1'h0,
  output logic latch_transparent = 1'h0
);
  // Bit 15 first so it lands on channel 15
  task automatic send(input logic [15:0] w, input int half);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      serial_in <= w[i];
      repeat (half) @(posedge clk);
      shift_clk <= 1'h1;
      repeat (half) @(posedge clk);
      shift_clk <= 1'h0;
    end
    repeat (half) @(posedge clk);
    serial_in <= ~w[0];
  endtask
  task automatic latch_pulse(input int len);
    @(posedge clk);
    latch_transparent <= 1'h1;
    repeat (len) @(posedge clk);
    latch_transparent <= 1'h0;
    repeat (len) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/lss_core_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module lss_core_bench;
  logic clk = 1'h0, arst_n = 1'h0, over_temp = 1'h0, out_enable_n = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, q;
  wire [31:0] avs_readdata;
  wire [15:0] sink_channel;
  wire shift_clk, serial_in, latch_transparent, serial_out, capture_ready, avs_waitrequest;
  int n_mismatch = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  lss_ctrl_model ctl (.clk, .shift_clk, .serial_in, .latch_transparent);
  lss_core DUT (.clk, .arst_n, .shift_clk, .serial_in, .serial_out, .latch_transparent, .out_enable_n,
    .over_temp, .sink_channel, .capture_ready, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Answer taken at the rising edge itself, before the design's own updates land
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic wt;
    int n = 0;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      wt = avs_waitrequest;
      q = avs_readdata;
      if (++n > 20) begin
        n_mismatch++;
        $display("[ERR] %0t bus timeout", $time);
        give_verdict;
      end
    end while (wt !== 1'h0);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic sink_is(input logic [15:0] e);
    int n = 0;
    while (sink_channel !== e && n++ < 30) @(negedge clk);
    chk(sink_channel, e);
  endtask
  task automatic pin(input logic oe_n, input logic hot);
    @(posedge clk);
    out_enable_n <= oe_n;
    over_temp <= hot;
  endtask
  task automatic t_shift;
    pin(1'h0, 1'h0);
    ctl.send(16'ha5c3, 3);
    ctl.latch_pulse(12);
    sink_is(16'ha5c3);
    chk(serial_out, 1'h1);
    rd(5'h08, 32'ha5c3);
    ctl.send(16'h0ff0, 6);
    chk(serial_out, 1'h0);
    sink_is(16'ha5c3);
    $display("shift test done");
  endtask
  task automatic t_gate;
    rd(5'h00, 32'h0);
    rd(5'h1c, 32'h0);
    pin(1'h1, 1'h0);
    sink_is(16'h0);
    rd(5'h0c, 32'ha5c3);
    pin(1'h0, 1'h0);
    sink_is(16'ha5c3);
    pin(1'h0, 1'h1);
    sink_is(16'h0);
    rd(5'h04, 32'h1);
    pin(1'h0, 1'h0);
    sink_is(16'ha5c3);
    bus(1'h1, 5'h00, 32'h1);
    sink_is(16'h0);
    $display("gate test done");
  endtask
  task automatic t_fifo;
    bus(1'h1, 5'h00, 32'h2);
    repeat (8) ctl.latch_pulse(3);
    chk(capture_ready, 1'h0);
    ctl.latch_pulse(3);
    rd(5'h04, 32'he);
    repeat (8) rd(5'h10, 32'h0ff0);
    rd(5'h10, 32'h0);
    bus(1'h1, 5'h04, 32'h4);
    rd(5'h04, 32'h0);
    $display("fifo test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    t_shift;
    t_gate;
    t_fifo;
    give_verdict;
  end
endmodule
`default_nettype wire
